//--- alu_pkg.sv
`default_nettype none
package alu_pkg;
   // Prefix class handed over by the sequencer
   localparam logic [2:0] PFX_NONE = 3'h0;
   localparam logic [2:0] PFX_CB   = 3'h1;
   localparam logic [2:0] PFX_ED   = 3'h2;
   localparam logic [2:0] PFX_DD   = 3'h3;
   localparam logic [2:0] PFX_FD   = 3'h4;
   localparam logic [2:0] PFX_DDCB = 3'h5;
   localparam logic [2:0] PFX_FDCB = 3'h6;
   // Flag bit positions
   localparam int FL_S  = 7;
   localparam int FL_Z  = 6;
   localparam int FL_H  = 4;
   localparam int FL_PV = 2;
   localparam int FL_N  = 1;
   localparam int FL_C  = 0;
   // Operand codes
   localparam logic [2:0] CODE_MEM = 3'h6;
   localparam logic [2:0] CODE_ACC = 3'h7;
   // 16-bit destination codes
   localparam logic [2:0] D16_BC = 3'h0;
   localparam logic [2:0] D16_DE = 3'h1;
   localparam logic [2:0] D16_HL = 3'h2;
   localparam logic [2:0] D16_SP = 3'h3;
   localparam logic [2:0] D16_IX = 3'h4;
   localparam logic [2:0] D16_IY = 3'h5;
   localparam logic [1:0] PAIR_PTR = 2'h2;
   // Opcodes and opcode fields
   localparam logic [4:0] OPC_OR_ROW  = 5'h16;
   localparam logic [4:0] OPC_CP_ROW  = 5'h17;
   localparam logic [7:0] OPC_OR_IMM  = 8'hf6;
   localparam logic [7:0] OPC_CP_IMM  = 8'hfe;
   localparam logic [2:0] OPC_INC8_LO = 3'h4;
   localparam logic [2:0] OPC_DEC8_LO = 3'h5;
   localparam logic [7:0] OPC_DAA     = 8'h27;
   localparam logic [7:0] OPC_CPL     = 8'h2f;
   localparam logic [7:0] OPC_CCF     = 8'h3f;
   localparam logic [7:0] OPC_SCF     = 8'h37;
   localparam logic [7:0] OPC_NEG     = 8'h44;
   localparam logic [7:0] OPC_RLD     = 8'h6f;
   localparam logic [7:0] OPC_RRD     = 8'h67;
   localparam logic [7:0] OPC_ACC_ROTATE_LEFT_CIRCULAR    = 8'h07;
   localparam logic [7:0] OPC_ACC_ROTATE_RIGHT_CIRCULAR    = 8'h0f;
   localparam logic [7:0] OPC_RLA     = 8'h17;
   localparam logic [7:0] OPC_RRA     = 8'h1f;
   localparam logic [3:0] OPC_ADD16_LO = 4'h9;
   localparam logic [3:0] OPC_ADC16_LO = 4'ha;
   localparam logic [3:0] OPC_SBC16_LO = 4'h2;
   localparam logic [3:0] OPC_INC16_LO = 4'h3;
   localparam logic [3:0] OPC_DEC16_LO = 4'hb;
   // Shift group codes in bits 5:3 of a CB opcode
   localparam logic [2:0] ROT_RLC = 3'h0;
   localparam logic [2:0] ROT_RRC = 3'h1;
   localparam logic [2:0] ROT_RL  = 3'h2;
   localparam logic [2:0] ROT_RR  = 3'h3;
   localparam logic [2:0] ROT_SLA = 3'h4;
   localparam logic [2:0] ROT_SRA = 3'h5;
   localparam logic [2:0] ROT_SRL = 3'h7;
   // BCD correction constants
   localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
   localparam logic [3:0] BCD_CORR      = 4'h6;
   localparam logic [7:0] BCD_BYTE_MAX  = 8'h99;
   // Reset values
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   typedef enum {OP_NONE, OP_OR, OP_CP, OP_INC8, OP_DEC8, OP_DAA, OP_CPL, OP_NEG,
                 OP_CCF, OP_SCF, OP_ADD16, OP_ADC16, OP_SBC16, OP_INC16, OP_DEC16,
                 OP_ROT, OP_AROT, OP_RLD, OP_RRD, OP_BIT, OP_SET, OP_RES} op_t;
endpackage
`default_nettype wire

//--- cpu_alu_exec.sv
// How it works
// - OR at B0+code, compare at B8+code; indexed and F6/FE immediate forms decoded.
// - 8-bit step up 04+8*code, step down 05+8*code, indexed 34/35.
// - Opcode 27 runs decimal adjust on the accumulator.
// - 3F inverts carry, 37 forces carry to one.
// - 2F inverts accumulator; ED 44 forms its twos complement.
// - 16-bit add into pointer pair 09..39; DD/FD retarget to index, 29 self.
// - ED 4A..7A add with carry into pointer pair.
// - ED 42..72 subtract with borrow from pointer pair.
// - 16-bit step up 03..33, down 0B..3B; DD/FD 23/2B on index registers.
// - CB group bases plus operand code; DD/FD CB d op for memory.
// - Shifts on accumulator, any register, memory; accumulator forms 07/0F/17/1F.
// - ED 6F/67 rotate accumulator low digit with both memory digits.
// - Set, clear or test any bit of accumulator, register or memory.
// - Bit test sets zero flag when bit is zero; operand unchanged.
// - Compare only updates flags; OR, DAA, CPL, NEG, RLD/RRD and 07/0F/17/1F results go to accumulator.
// - Subtract flag marks subtraction so decimal adjust corrects both ways.
// - Carry flag takes part in 16-bit add/subtract with carry; all flags set.
`default_nettype none
module cpu_alu_exec
   import alu_pkg::*;
(
   // Clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        SRST,
   // Request from the sequencer
   input  wire logic        START,
   input  wire logic [2:0]  PREFIX,
   input  wire logic [7:0]  OPCODE,
   // Operands
   input  wire logic [7:0]  ACC_IN,
   input  wire logic [7:0]  FLAGS_IN,
   input  wire logic [7:0]  OPND8,
   input  wire logic [15:0] COUNTER_PAIR,
   input  wire logic [15:0] SECOND_PAIR,
   input  wire logic [15:0] POINTER_PAIR,
   input  wire logic [15:0] STACK_POINTER,
   input  wire logic [15:0] INDEX_REG_ONE,
   input  wire logic [15:0] INDEX_REG_TWO,
   // Results
   output logic             DONE,
   output logic             ILLEGAL,
   output logic [7:0]       ACC_OUT,
   output logic [7:0]       FLAGS_OUT,
   output logic [7:0]       RES8,
   output logic             WR_ACC,
   output logic             WR_FLAGS,
   output logic             WR_OPND,
   output logic [2:0]       OPND_CODE,
   output logic [15:0]      RES16,
   output logic             WR_16,
   output logic [2:0]       DST16
);

   ////////////////////////////////////////////////////////////////////////////
   // Arithmetic helpers returning {flags, result}
   function automatic logic [15:0] arith8(input logic [7:0] a, input logic [7:0] b,
                                          input logic cin, input logic sub);
      logic [7:0] bb;
      logic       cc;
      logic [8:0] r;
      logic [4:0] h;
      bb = sub ? ~b : b;
      cc = sub ? ~cin : cin;
      r  = {1'b0, a} + {1'b0, bb} + {8'h00, cc};
      h  = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cc};
      return {r[7], r[7:0] == 8'h00, 1'b0, h[4] ^ sub, 1'b0,
              (a[7] == bb[7]) && (r[7] != a[7]), sub, r[8] ^ sub, r[7:0]};
   endfunction

   function automatic logic [23:0] arith16(input logic [15:0] a, input logic [15:0] b,
                                           input logic cin, input logic sub);
      logic [15:0] bb;
      logic        cc;
      logic [16:0] r;
      logic [12:0] h;
      bb = sub ? ~b : b;
      cc = sub ? ~cin : cin;
      r  = {1'b0, a} + {1'b0, bb} + {16'h0000, cc};
      h  = {1'b0, a[11:0]} + {1'b0, bb[11:0]} + {12'h000, cc};
      return {r[15], r[15:0] == 16'h0000, 1'b0, h[12] ^ sub, 1'b0,
              (a[15] == bb[15]) && (r[15] != a[15]), sub, r[16] ^ sub, r[15:0]};
   endfunction

   // Sign, zero and parity with given carry, H and N clear
   function automatic logic [7:0] szp(input logic [7:0] x, input logic c);
      return {x[7], x == 8'h00, 1'b0, 1'b0, 1'b0, ~^x, 1'b0, c};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   op_t         op;
   logic        idx_pfx;
   logic        cb_idx;
   logic [2:0]  code;
   logic [7:0]  src8;
   logic        bit_sel;
   logic [15:0] ptr16;
   logic [15:0] src16;
   logic [2:0]  ptr_code;

   always_comb begin
      idx_pfx  = (PREFIX == PFX_DD) || (PREFIX == PFX_FD);
      cb_idx   = (PREFIX == PFX_DDCB) || (PREFIX == PFX_FDCB);
      ptr16    = (PREFIX == PFX_DD) ? INDEX_REG_ONE :
                 (PREFIX == PFX_FD) ? INDEX_REG_TWO : POINTER_PAIR;
      ptr_code = (PREFIX == PFX_DD) ? D16_IX : (PREFIX == PFX_FD) ? D16_IY : D16_HL;
      op       = OP_NONE;
      code     = (PREFIX == PFX_NONE || idx_pfx) && OPCODE[7:6] == 2'h0 ?
                 OPCODE[5:3] : OPCODE[2:0];
      if (cb_idx) begin
         code = CODE_MEM;
      end
      if (PREFIX == PFX_NONE || idx_pfx) begin
         if (OPCODE[7:3] == OPC_OR_ROW || (PREFIX == PFX_NONE && OPCODE == OPC_OR_IMM)) begin
            op = OP_OR;
         end else if (OPCODE[7:3] == OPC_CP_ROW ||
                      (PREFIX == PFX_NONE && OPCODE == OPC_CP_IMM)) begin
            op = OP_CP;
         end else if (OPCODE[7:6] == 2'h0 && OPCODE[2:0] == OPC_INC8_LO) begin
            op = OP_INC8;
         end else if (OPCODE[7:6] == 2'h0 && OPCODE[2:0] == OPC_DEC8_LO) begin
            op = OP_DEC8;
         end else if (OPCODE[7:6] == 2'h0 && OPCODE[3:0] == OPC_ADD16_LO) begin
            op = OP_ADD16;
         end else if (OPCODE[7:6] == 2'h0 && OPCODE[3:0] == OPC_INC16_LO) begin
            op = OP_INC16;
         end else if (OPCODE[7:6] == 2'h0 && OPCODE[3:0] == OPC_DEC16_LO) begin
            op = OP_DEC16;
         end else if (PREFIX == PFX_NONE && OPCODE == OPC_DAA) begin
            op = OP_DAA;
         end else if (PREFIX == PFX_NONE && OPCODE == OPC_CPL) begin
            op = OP_CPL;
         end else if (PREFIX == PFX_NONE && OPCODE == OPC_CCF) begin
            op = OP_CCF;
         end else if (PREFIX == PFX_NONE && OPCODE == OPC_SCF) begin
            op = OP_SCF;
         end else if (PREFIX == PFX_NONE && (OPCODE == OPC_ACC_ROTATE_LEFT_CIRCULAR || OPCODE == OPC_ACC_ROTATE_RIGHT_CIRCULAR ||
                      OPCODE == OPC_RLA || OPCODE == OPC_RRA)) begin
            op = OP_AROT;
         end
         // Indexed forms reach only memory or the index register itself
         if (idx_pfx && (op == OP_OR || op == OP_CP || op == OP_INC8 || op == OP_DEC8) &&
             code != CODE_MEM) begin
            op = OP_NONE;
         end
         if (idx_pfx && (op == OP_INC16 || op == OP_DEC16) && OPCODE[5:4] != PAIR_PTR) begin
            op = OP_NONE;
         end
      end else if (PREFIX == PFX_ED) begin
         if (OPCODE == OPC_NEG) begin
            op = OP_NEG;
         end else if (OPCODE == OPC_RLD) begin
            op = OP_RLD;
         end else if (OPCODE == OPC_RRD) begin
            op = OP_RRD;
         end else if (OPCODE[7:6] == 2'h1 && OPCODE[3:0] == OPC_ADC16_LO) begin
            op = OP_ADC16;
         end else if (OPCODE[7:6] == 2'h1 && OPCODE[3:0] == OPC_SBC16_LO) begin
            op = OP_SBC16;
         end
      end else if (PREFIX == PFX_CB || cb_idx) begin
         case (OPCODE[7:6])
            2'h0:    op = (OPCODE[5:3] == 3'h6) ? OP_NONE : OP_ROT;
            2'h1:    op = OP_BIT;
            2'h2:    op = OP_RES;
            default: op = OP_SET;
         endcase
      end
      src8    = (code == CODE_ACC) ? ACC_IN : OPND8;
      if (op == OP_OR || op == OP_CP) begin
         src8 = (OPCODE[2:0] == CODE_ACC && OPCODE[7:6] != 2'h3) ? ACC_IN : OPND8;
      end
      bit_sel = src8[OPCODE[5:3]];
      case (OPCODE[5:4])
         2'h0:    src16 = COUNTER_PAIR;
         2'h1:    src16 = SECOND_PAIR;
         2'h2:    src16 = ptr16;
         default: src16 = STACK_POINTER;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Execute
   logic        done_r, ill_r, wacc_r, wfl_r, wop_r, w16_r;
   logic        done_nxt, ill_nxt, wacc_nxt, wfl_nxt, wop_nxt, w16_nxt;
   logic [7:0]  acc_r, fl_r, res8_r, acc_nxt, fl_nxt, res8_nxt;
   logic [15:0] res16_r, res16_nxt;
   logic [2:0]  code_r, dst_r, code_nxt, dst_nxt;

   always_comb begin
      logic [15:0] a8;
      logic [23:0] a16;
      logic [7:0]  corr;
      logic        cy;
      logic        outb;
      a8        = 16'h0000;
      a16       = 24'h000000;
      corr      = 8'h00;
      cy        = FLAGS_IN[FL_C];
      outb      = 1'b0;
      done_nxt  = START;
      ill_nxt   = START && (op == OP_NONE);
      acc_nxt   = ACC_IN;
      fl_nxt    = FLAGS_IN;
      res8_nxt  = src8;
      res16_nxt = RST_WORD;
      code_nxt  = code;
      dst_nxt   = D16_HL;
      wacc_nxt  = 1'b0;
      wfl_nxt   = 1'b0;
      wop_nxt   = 1'b0;
      w16_nxt   = 1'b0;
      case (op)
         OP_OR: begin
            acc_nxt = ACC_IN | src8;
            fl_nxt  = szp(acc_nxt, 1'b0);
            wacc_nxt = 1'b1;
            wfl_nxt  = 1'b1;
         end
         OP_CP, OP_NEG: begin
            a8      = (op == OP_CP) ? arith8(ACC_IN, src8, 1'b0, 1'b1) :
                                      arith8(8'h00, ACC_IN, 1'b0, 1'b1);
            fl_nxt  = a8[15:8];
            acc_nxt = a8[7:0];
            wacc_nxt = (op == OP_NEG);
            wfl_nxt  = 1'b1;
         end
         OP_INC8, OP_DEC8: begin
            a8       = arith8(src8, 8'h01, 1'b0, op == OP_DEC8);
            fl_nxt   = {a8[15:9], FLAGS_IN[FL_C]};
            res8_nxt = a8[7:0];
            acc_nxt  = a8[7:0];
            wacc_nxt = (code == CODE_ACC);
            wop_nxt  = (code != CODE_ACC);
            wfl_nxt  = 1'b1;
         end
         OP_DAA: begin
            if (FLAGS_IN[FL_H] || ACC_IN[3:0] > BCD_DIGIT_MAX) corr[3:0] = BCD_CORR;
            if (FLAGS_IN[FL_C] || ACC_IN > BCD_BYTE_MAX) begin
               corr[7:4] = BCD_CORR;
               cy        = 1'b1;
            end
            acc_nxt = FLAGS_IN[FL_N] ? ACC_IN - corr : ACC_IN + corr;
            fl_nxt  = szp(acc_nxt, cy);
            fl_nxt[FL_N] = FLAGS_IN[FL_N];
            fl_nxt[FL_H] = FLAGS_IN[FL_N] ? (FLAGS_IN[FL_H] && ACC_IN[3:0] < BCD_CORR) :
                                            (ACC_IN[3:0] > BCD_DIGIT_MAX);
            wacc_nxt = 1'b1;
            wfl_nxt  = 1'b1;
         end
         OP_CPL: begin
            acc_nxt = ~ACC_IN;
            fl_nxt[FL_H] = 1'b1;
            fl_nxt[FL_N] = 1'b1;
            wacc_nxt = 1'b1;
            wfl_nxt  = 1'b1;
         end
         OP_CCF, OP_SCF: begin
            fl_nxt[FL_H] = (op == OP_CCF) && FLAGS_IN[FL_C];
            fl_nxt[FL_N] = 1'b0;
            fl_nxt[FL_C] = (op == OP_SCF) || !FLAGS_IN[FL_C];
            wfl_nxt = 1'b1;
         end
         OP_ADD16, OP_ADC16, OP_SBC16: begin
            a16 = arith16(ptr16, src16, (op != OP_ADD16) && FLAGS_IN[FL_C],
                          op == OP_SBC16);
            res16_nxt = a16[15:0];
            dst_nxt   = ptr_code;
            fl_nxt    = a16[23:16];
            if (op == OP_ADD16) begin
               fl_nxt = {FLAGS_IN[7:5], a16[20], FLAGS_IN[3:2], 1'b0, a16[16]};
            end
            w16_nxt = 1'b1;
            wfl_nxt = 1'b1;
         end
         OP_INC16, OP_DEC16: begin
            res16_nxt = (op == OP_INC16) ? src16 + 16'h0001 : src16 - 16'h0001;
            dst_nxt   = (OPCODE[5:4] == PAIR_PTR) ? ptr_code : {1'b0, OPCODE[5:4]};
            w16_nxt   = 1'b1;
         end
         OP_ROT, OP_AROT: begin
            case (OPCODE[5:3])
               ROT_RLC: {outb, res8_nxt} = {src8, src8[7]};
               ROT_RRC: {res8_nxt, outb} = {src8[0], src8};
               ROT_RL:  {outb, res8_nxt} = {src8, FLAGS_IN[FL_C]};
               ROT_RR:  {res8_nxt, outb} = {FLAGS_IN[FL_C], src8};
               ROT_SLA: {outb, res8_nxt} = {src8, 1'b0};
               ROT_SRA: {res8_nxt, outb} = {src8[7], src8};
               default: {res8_nxt, outb} = {1'b0, src8};
            endcase
            if (op == OP_AROT) begin
               res8_nxt = {ACC_IN[6:0], 1'b0};
               case (OPCODE)
                  OPC_ACC_ROTATE_LEFT_CIRCULAR: {outb, res8_nxt} = {ACC_IN, ACC_IN[7]};
                  OPC_ACC_ROTATE_RIGHT_CIRCULAR: {res8_nxt, outb} = {ACC_IN[0], ACC_IN};
                  OPC_RLA:  {outb, res8_nxt} = {ACC_IN, FLAGS_IN[FL_C]};
                  default:  {res8_nxt, outb} = {FLAGS_IN[FL_C], ACC_IN};
               endcase
               fl_nxt = {FLAGS_IN[7:5], 1'b0, FLAGS_IN[3:2], 1'b0, outb};
            end else begin
               fl_nxt = szp(res8_nxt, outb);
            end
            acc_nxt  = res8_nxt;
            wacc_nxt = (op == OP_AROT) || (code == CODE_ACC);
            wop_nxt  = !wacc_nxt;
            wfl_nxt  = 1'b1;
         end
         OP_RLD, OP_RRD: begin
            // Three-digit rotation through accumulator low digit and memory byte
            if (op == OP_RLD) begin
               res8_nxt = {OPND8[3:0], ACC_IN[3:0]};
               acc_nxt  = {ACC_IN[7:4], OPND8[7:4]};
            end else begin
               res8_nxt = {ACC_IN[3:0], OPND8[7:4]};
               acc_nxt  = {ACC_IN[7:4], OPND8[3:0]};
            end
            code_nxt = CODE_MEM;
            fl_nxt   = szp(acc_nxt, FLAGS_IN[FL_C]);
            wacc_nxt = 1'b1;
            wop_nxt  = 1'b1;
            wfl_nxt  = 1'b1;
         end
         OP_BIT: begin
            fl_nxt[FL_Z] = !bit_sel;
            fl_nxt[FL_H] = 1'b1;
            fl_nxt[FL_N] = 1'b0;
            wfl_nxt      = 1'b1;
         end
         OP_SET, OP_RES: begin
            res8_nxt[OPCODE[5:3]] = (op == OP_SET);
            acc_nxt  = res8_nxt;
            wacc_nxt = (code == CODE_ACC);
            wop_nxt  = (code != CODE_ACC);
         end
         default: ;
      endcase
      if (!START) begin
         wacc_nxt = 1'b0;
         wfl_nxt  = 1'b0;
         wop_nxt  = 1'b0;
         w16_nxt  = 1'b0;
      end
   end

   // Result registers
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         done_r  <= 1'b0;
         ill_r   <= 1'b0;
         wacc_r  <= 1'b0;
         wfl_r   <= 1'b0;
         wop_r   <= 1'b0;
         w16_r   <= 1'b0;
         acc_r   <= RST_BYTE;
         fl_r    <= RST_BYTE;
         res8_r  <= RST_BYTE;
         res16_r <= RST_WORD;
         code_r  <= 3'h0;
         dst_r   <= 3'h0;
      end else begin
         done_r  <= done_nxt;
         ill_r   <= ill_nxt;
         wacc_r  <= wacc_nxt;
         wfl_r   <= wfl_nxt;
         wop_r   <= wop_nxt;
         w16_r   <= w16_nxt;
         acc_r   <= acc_nxt;
         fl_r    <= fl_nxt;
         res8_r  <= res8_nxt;
         res16_r <= res16_nxt;
         code_r  <= code_nxt;
         dst_r   <= dst_nxt;
      end
   end

   assign DONE      = done_r;
   assign ILLEGAL   = ill_r;
   assign ACC_OUT   = acc_r;
   assign FLAGS_OUT = fl_r;
   assign RES8      = res8_r;
   assign WR_ACC    = wacc_r;
   assign WR_FLAGS  = wfl_r;
   assign WR_OPND   = wop_r;
   assign OPND_CODE = code_r;
   assign RES16     = res16_r;
   assign WR_16     = w16_r;
   assign DST16     = dst_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb_main @(posedge CORE_CLK); endclocking
   default disable iff (SRST);

   a_or_imm_result: assert property (START && PREFIX == PFX_NONE && OPCODE == OPC_OR_IMM
      |=> WR_ACC && ACC_OUT == ($past(ACC_IN) | $past(OPND8))) else $error("or result wrong");
   a_cp_keeps_acc: assert property (START && PREFIX == PFX_NONE && OPCODE == OPC_CP_IMM
      |=> DONE && !WR_ACC && WR_FLAGS && FLAGS_OUT[FL_N]) else $error("compare wrote acc");
   a_inc_acc_carry: assert property (START && PREFIX == PFX_NONE && OPCODE[7:6] == 2'h0
      && OPCODE[5:3] == CODE_ACC && OPCODE[2:0] == OPC_INC8_LO
      |=> ACC_OUT == 8'($past(ACC_IN) + 8'h01) && FLAGS_OUT[FL_C] == $past(FLAGS_IN[FL_C]))
      else $error("acc step up wrong");
   a_ccf_flips_carry: assert property (START && PREFIX == PFX_NONE && OPCODE == OPC_CCF
      |=> FLAGS_OUT[FL_C] != $past(FLAGS_IN[FL_C])) else $error("carry not flipped");
   a_cpl_inverts: assert property (START && PREFIX == PFX_NONE && OPCODE == OPC_CPL
      |=> WR_ACC && ACC_OUT == ~$past(ACC_IN)) else $error("acc not inverted");
   a_neg_twos: assert property (START && PREFIX == PFX_ED && OPCODE == OPC_NEG
      |=> ACC_OUT == 8'(8'h00 - $past(ACC_IN)) && FLAGS_OUT[FL_N]) else $error("negate wrong");
   a_add16_dest: assert property (START && PREFIX == PFX_DD && OPCODE[7:6] == 2'h0
      && OPCODE[3:0] == OPC_ADD16_LO |=> WR_16 && DST16 == D16_IX) else $error("add16 dest");
   a_sbc16_borrow: assert property (START && PREFIX == PFX_ED
      && OPCODE == {2'h1, 2'h0, OPC_SBC16_LO} |=> RES16 == 16'($past(POINTER_PAIR)
      - $past(COUNTER_PAIR) - {15'h0000, $past(FLAGS_IN[FL_C])})) else $error("sbc16 wrong");
   a_bit_test_zero: assert property (START && PREFIX == PFX_CB && OPCODE[7:6] == 2'h1
      |=> FLAGS_OUT[FL_Z] == !$past(bit_sel) && !WR_OPND && !WR_ACC) else $error("bit test");
   a_srl_zero_fill: assert property (START && PREFIX == PFX_CB && OPCODE[5:3] == ROT_SRL
      && OPCODE[7:6] == 2'h0 && OPCODE[2:0] != CODE_ACC
      |=> WR_OPND && RES8 == ($past(OPND8) >> 1)) else $error("srl fill wrong");
   a_done_follows: assert property (START |=> DONE ##1 (DONE == $past(START)))
      else $error("done timing wrong");

   c_indexed_shift: cover property (START && PREFIX == PFX_DDCB && OPCODE[7:6] == 2'h0);
   c_daa_after_sub: cover property (START && OPCODE == OPC_DAA && FLAGS_IN[FL_N]);
   c_rld_run:       cover property (START && PREFIX == PFX_ED && OPCODE == OPC_RLD ##1 DONE);

endmodule
`default_nettype wire

//--- regfile_model.sv
`default_nettype none
module regfile_model (
   // Register pairs handed to the datapath
   output logic [15:0] counter_pair,
   output logic [15:0] second_pair,
   output logic [15:0] pointer_pair,
   output logic [15:0] stack_pointer,
   output logic [15:0] index_reg_one,
   output logic [15:0] index_reg_two
);
   timeunit 1ns;
   timeprecision 1ps;
   // Distinct fixed contents so a wrong source shows up
   assign counter_pair  = 16'h0234;
   assign second_pair   = 16'h1111;
   assign pointer_pair  = 16'h1000;
   assign stack_pointer = 16'hfffe;
   assign index_reg_one = 16'h4000;
   assign index_reg_two = 16'h0000;
endmodule
`default_nettype wire

//--- cpu_alu_shift_bit_ops_tb.sv
`default_nettype none
module cpu_alu_shift_bit_ops_tb;
   import alu_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, start, done, illegal, wr_acc, wr_fl, wr_op, wr16;
   logic [2:0] pfx, opc_code, dst16;
   logic [7:0] opc, acc, fl, op8, acc_o, fl_o, res8;
   logic [15:0] bc, de, hl, sp, ix, iy, res16;
   int fails, checked;
   regfile_model regfile_model_i (.counter_pair(bc), .second_pair(de), .pointer_pair(hl),
      .stack_pointer(sp), .index_reg_one(ix), .index_reg_two(iy));
   cpu_alu_exec cpu_alu_exec_i (.CORE_CLK(clk), .SRST(rst), .START(start), .PREFIX(pfx),
      .OPCODE(opc), .ACC_IN(acc), .FLAGS_IN(fl), .OPND8(op8), .COUNTER_PAIR(bc),
      .SECOND_PAIR(de), .POINTER_PAIR(hl), .STACK_POINTER(sp), .INDEX_REG_ONE(ix),
      .INDEX_REG_TWO(iy), .DONE(done), .ILLEGAL(illegal), .ACC_OUT(acc_o),
      .FLAGS_OUT(fl_o), .RES8(res8), .WR_ACC(wr_acc), .WR_FLAGS(wr_fl), .WR_OPND(wr_op),
      .OPND_CODE(opc_code), .RES16(res16), .WR_16(wr16), .DST16(dst16));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Verdict and end of run
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         fails++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // One instruction, then a bounded wait for its answer
   task automatic issue(input logic [2:0] p, input logic [7:0] o, a, f, d);
      int n;
      n = 0;
      @(posedge clk);
      pfx <= p; opc <= o; acc <= a; fl <= f; op8 <= d; start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      #1;
      while (done !== 1'b1 && n < 4) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 4) begin
         fails++;
         print_verdict();
      end
   endtask
   task automatic t_or_cp();
      issue(PFX_NONE, 8'hf6, 8'h12, 8'h00, 8'h21); chk(acc_o, 8'h33);
      issue(PFX_NONE, 8'hb2, 8'h0f, 8'h00, 8'hf0); chk(acc_o, 8'hff);
      issue(PFX_NONE, 8'hfe, 8'h12, 8'h00, 8'h12); chk(wr_acc, 1'b0);
      chk({fl_o[FL_Z], fl_o[FL_N]}, 2'h3);
   endtask
   task automatic t_step8();
      issue(PFX_NONE, 8'h3c, 8'hff, 8'h01, 8'h00); chk({acc_o, fl_o[FL_Z], fl_o[FL_C]}, 10'h003);
      issue(PFX_NONE, 8'h35, 8'h00, 8'h00, 8'h01); chk({res8, wr_op, opc_code}, 12'h00e);
      issue(PFX_DD, 8'h34, 8'h00, 8'h00, 8'h7f); chk(res8, 8'h80);
   endtask
   task automatic t_acc_ops();
      issue(PFX_NONE, 8'h27, 8'h1a, 8'h00, 8'h00); chk(acc_o, 8'h20);
      issue(PFX_NONE, 8'h3f, 8'h00, 8'h01, 8'h00); chk(fl_o[FL_C], 1'b0);
      issue(PFX_NONE, 8'h37, 8'h00, 8'h00, 8'h00); chk(fl_o[FL_C], 1'b1);
      issue(PFX_NONE, 8'h2f, 8'h5a, 8'h00, 8'h00); chk(acc_o, 8'ha5);
      issue(PFX_ED, 8'h44, 8'h01, 8'h00, 8'h00); chk(acc_o, 8'hff);
   endtask
   task automatic t_arith16();
      issue(PFX_NONE, 8'h09, 8'h00, 8'h00, 8'h00); chk({res16, dst16}, {16'h1234, 3'h2});
      issue(PFX_DD, 8'h29, 8'h00, 8'h00, 8'h00); chk({res16, dst16}, {16'h8000, 3'h4});
      issue(PFX_ED, 8'h4a, 8'h00, 8'h01, 8'h00); chk(res16, 16'h1235);
      issue(PFX_ED, 8'h42, 8'h00, 8'h01, 8'h00); chk({res16, wr_fl}, {16'h0dcb, 1'b1});
      issue(PFX_NONE, 8'h23, 8'h00, 8'h00, 8'h00); chk(res16, 16'h1001);
      issue(PFX_FD, 8'h2b, 8'h00, 8'h00, 8'h00); chk({res16, dst16}, {16'hffff, 3'h5});
      chk({wr16, wr_fl, wr_acc}, 3'h4);
   endtask
   // Undecoded codes answer with the error pulse and no strobes
   task automatic t_illegal();
      issue(PFX_CB, 8'h30, 8'h00, 8'h00, 8'h81); chk({illegal, wr_acc, wr_fl, wr_op, wr16}, 5'h10);
      issue(PFX_DD, 8'hb0, 8'h00, 8'h00, 8'h81); chk({illegal, wr_acc, wr_fl}, 3'h4);
      issue(PFX_NONE, 8'hb0, 8'h01, 8'h00, 8'h80); chk({illegal, acc_o}, 9'h081);
   endtask
   // Reset in mid-run drops a pending request and clears done, WR_ACC, WR_FLAGS, accumulator and flag outputs
   task automatic t_reset();
      @(posedge clk);
      rst <= 1'b1;
      pfx <= PFX_NONE;
      opc <= 8'hf6;
      acc <= 8'h12;
      op8 <= 8'h21;
      start <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk({done, wr_acc, wr_fl, acc_o, fl_o}, 19'h00000);
      @(posedge clk);
      rst <= 1'b0;
      start <= 1'b0;
      @(posedge clk);
      #1;
      chk({done, wr_acc}, 2'h0);
   endtask
   task automatic t_shift();
      logic [7:0] so[5] = '{8'h13, 8'h1b, 8'h23, 8'h2b, 8'h3b};
      logic [7:0] se[5] = '{8'h02, 8'h40, 8'h02, 8'hc0, 8'h40};
      for (int i = 0; i < 5; i++) begin
         issue(PFX_CB, so[i], 8'h00, 8'h00, 8'h81); chk({res8, fl_o[FL_C]}, {se[i], 1'b1});
      end
      issue(PFX_NONE, 8'h07, 8'h81, 8'h00, 8'h00); chk({acc_o, fl_o[FL_C]}, 9'h007);
      issue(PFX_NONE, 8'h1f, 8'h01, 8'h00, 8'h00); chk({acc_o, fl_o[FL_C]}, 9'h001);
   endtask
   task automatic t_bcd_rot();
      issue(PFX_ED, 8'h6f, 8'h12, 8'h00, 8'h34); chk({acc_o, res8}, 16'h1342);
      issue(PFX_ED, 8'h67, 8'h12, 8'h00, 8'h34); chk({acc_o, res8}, 16'h1423);
   endtask
   task automatic t_bits();
      issue(PFX_CB, 8'h46, 8'h00, 8'h00, 8'hfe); chk({fl_o[FL_Z], wr_op}, 2'h2);
      issue(PFX_CB, 8'h78, 8'h00, 8'h00, 8'h80); chk(fl_o[FL_Z], 1'b0);
      issue(PFX_CB, 8'hc0, 8'h00, 8'h00, 8'h00); chk(res8, 8'h01);
      issue(PFX_CB, 8'hb8, 8'h00, 8'h00, 8'hff); chk(res8, 8'h7f);
   endtask
   initial begin
      fails = 0; checked = 0; rst = 1'b1; start = 1'b0; pfx = PFX_NONE;
      opc = 8'h00; acc = 8'h00; fl = 8'h00; op8 = 8'h00;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_or_cp();
      t_step8();
      t_acc_ops();
      t_arith16();
      t_shift();
      t_bcd_rot();
      t_bits();
      t_illegal();
      t_reset();
      t_or_cp();
      print_verdict();
   end
endmodule
`default_nettype wire
